// File: rtl/tps_dither.sv
`timescale 1ns/10ps
`default_nettype none
module tps_dither (
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst_n,
   input  wire logic        i_en,
   input  wire logic        i_samp_vld,
   input  wire logic [12:0] i_imp,
   input  wire logic [1:0]  i_dith_sel,
   output logic             o_dith_vld,
   output logic [12:0]      o_dith
);
   // ==========================================
   // Dithered sample accumulator
   logic [5:0]  cnt_r,  cnt_nxt;
   logic [17:0] sum_r,  sum_nxt;
   logic        vld_r,  vld_nxt;
   logic [12:0] dith_r, dith_nxt;
   logic [2:0]  log2n;
   logic [17:0] acc;
   logic [17:0] scaled;

   always_comb begin
      log2n    = tps_pkg::DITH_LOG2_BASE + {1'b0, i_dith_sel};
      acc      = sum_r + {5'h00, i_imp};
      scaled   = acc >> (log2n - tps_pkg::DITH_LOG2_BASE);
      cnt_nxt  = cnt_r;
      sum_nxt  = sum_r;
      vld_nxt  = 1'b0;
      dith_nxt = dith_r;
      if (!i_en) begin
         cnt_nxt = 6'h00;
         sum_nxt = 18'h00000;
      end else if (i_samp_vld) begin
         // Factor of 4, 8, 16 or 32 samples per result
         if (cnt_r == 6'((6'h01 << log2n) - 6'h01)) begin
            cnt_nxt  = 6'h00;
            sum_nxt  = 18'h00000;
            vld_nxt  = 1'b1;
            dith_nxt = (scaled > {5'h00, tps_pkg::IMP_MAX}) ? tps_pkg::IMP_MAX : scaled[12:0];
         end else begin
            cnt_nxt = cnt_r + 6'h01;
            sum_nxt = acc;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_r  <= 6'h00;
         sum_r  <= 18'h00000;
         vld_r  <= 1'b0;
         dith_r <= tps_pkg::RST_IMP;
      end else begin
         cnt_r  <= cnt_nxt;
         sum_r  <= sum_nxt;
         vld_r  <= vld_nxt;
         dith_r <= dith_nxt;
      end
   end

   assign o_dith_vld = vld_r;
   assign o_dith     = dith_r;

   a_dith_idle: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      !i_en |=> !o_dith_vld) else $error("Dithered result while disabled");
endmodule : tps_dither
`default_nettype wire

// File: rtl/tps_pkg.sv
package tps_pkg;
   // ==========================================
   // Register offsets
   localparam logic [7:0] ADDR_CTRL       = 8'h90;
   localparam logic [7:0] ADDR_GROUP_LO   = 8'h92;
   localparam logic [7:0] ADDR_GROUP_HI   = 8'h93;
   localparam logic [7:0] ADDR_PROX_CFG   = 8'h96;
   localparam logic [7:0] ADDR_PROX_VAR   = 8'h97;
   localparam logic [7:0] ADDR_PROX_ENV   = 8'h98;
   localparam logic [7:0] ADDR_FILT_LO    = 8'h9a;
   localparam logic [7:0] ADDR_FILT_HI    = 8'h9b;
   localparam logic [7:0] ADDR_RESULT_LO  = 8'hb0;
   localparam logic [7:0] ADDR_RESULT_HI  = 8'hb1;
   localparam logic [7:0] ADDR_LIVE_LO    = 8'hb4;
   localparam logic [7:0] ADDR_LIVE_HI    = 8'hb5;
   // ==========================================
   // Reset values
   localparam logic [7:0]  RST_BYTE       = 8'h00;
   localparam logic [15:0] RST_WORD       = 16'h0000;
   localparam logic [12:0] RST_IMP        = 13'h0000;
   // ==========================================
   // Field positions
   localparam int CTRL_PICK_MSB           = 7;
   localparam int CTRL_PICK_LSB           = 4;
   localparam int CTRL_PROX_EN            = 2;
   localparam int CTRL_MODE_MSB           = 1;
   localparam int CFG_DITH_MSB            = 7;
   localparam int CFG_DITH_LSB            = 6;
   localparam int CFG_INTV_MSB            = 4;
   localparam int CFG_INTV_LSB            = 2;
   localparam int CFG_ACC_MSB             = 1;
   localparam int ENV_FORCE               = 7;
   localparam int RES_DETECT              = 15;
   localparam int RES_CAL_DONE            = 14;
   // ==========================================
   // Sizes and codes
   localparam int NCH                     = 16;
   localparam int IMPW                    = 13;
   localparam int SUMW                    = 18;
   localparam logic [2:0] INTV_MAX_CODE   = 3'h4;
   localparam logic [1:0] ACC_DITH        = 2'h0;
   localparam logic [1:0] ACC_CAL         = 2'h1;
   localparam logic [2:0] DITH_LOG2_BASE  = 3'h2;
   localparam logic [12:0] IMP_MAX        = 13'h1fff;
endpackage : tps_pkg

// File: rtl/tps_status.sv
// Behaviour
// - Filtered key word: low byte channels 7..0, high byte 15..8, one means touched.
// - Live touch map, low byte at lower address, high byte next.
// - Live bit compares impedance drop with threshold using hysteresis, unfiltered.
// - Live map is not latched; a read returns the present state.
// - Config bits 7:6 pick dithering of 4, 8, 16 or 32 samples.
// - Larger dithering gives more sensitivity but slower result updates.
// - Config bits 4:2 pick calibration interval 1, 2, 4, 8, 16 dithered results.
// - Config bits 1:0 pick dithered or calibrated dithered value for result.
// - Eight-bit proximity variance threshold, read/write, resets to zero.
// - Environment threshold governs automatic proximity recalibration.
// - While force bit 7 set, current dithered value loads as calibrated.
// - Done flag at result bit 14 drops when force bit is raised and sets once the forced load completes.
// - Result bit 15 shows live proximity detection of selected channel.
// - Result bits 12:0 carry chosen impedance; bit 13 reads zero.
// - Result read as two read-only bytes, low byte first address.
// - Filtered word follows key filter and stays readable with filtering off.
// - Filter mode 0 none; 1, 2, 3 keep that many largest changes.
// - Group mask bit n includes channel n in key filtering.
// - Proximity runs only when enabled; four-bit field picks its channel.
`timescale 1ns/10ps
`default_nettype none
module tps_status (
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst_n,
   input  wire logic [7:0]  i_reg_addr,
   input  wire logic        i_reg_wr,
   input  wire logic [7:0]  i_reg_wdata,
   input  wire logic        i_reg_rd,
   input  wire logic        i_samp_vld,
   input  wire logic [3:0]  i_samp_chan,
   input  wire logic [12:0] i_samp_imp,
   input  wire logic [12:0] i_samp_cal,
   input  wire logic [7:0]  i_touch_thr,
   output logic [7:0]       o_reg_rdata,
   output logic [15:0]      o_filtered_keys,
   output logic             o_prox_detected
);
   // ==========================================
   // Register file
   logic [7:0]  ctrl_r,  ctrl_nxt;
   logic [15:0] group_r, group_nxt;
   logic [7:0]  cfg_r,   cfg_nxt;
   logic [7:0]  pvar_r,  pvar_nxt;
   logic [7:0]  penv_r,  penv_nxt;
   logic [7:0]  rdata_r, rdata_nxt;
   logic [15:0] live_r,  live_nxt;
   logic [15:0] filt_r,  filt_nxt;
   logic [15:0] result;

   always_comb begin
      ctrl_nxt  = ctrl_r;
      group_nxt = group_r;
      cfg_nxt   = cfg_r;
      pvar_nxt  = pvar_r;
      penv_nxt  = penv_r;
      if (i_reg_wr) begin
         unique case (i_reg_addr)
            tps_pkg::ADDR_CTRL:      ctrl_nxt         = i_reg_wdata;
            tps_pkg::ADDR_GROUP_LO:  group_nxt[7:0]   = i_reg_wdata;
            tps_pkg::ADDR_GROUP_HI:  group_nxt[15:8]  = i_reg_wdata;
            tps_pkg::ADDR_PROX_CFG:  cfg_nxt          = i_reg_wdata;
            tps_pkg::ADDR_PROX_VAR:  pvar_nxt         = i_reg_wdata;
            tps_pkg::ADDR_PROX_ENV:  penv_nxt         = i_reg_wdata;
            default: ;
         endcase
      end
   end

   // Read mux; status words come straight from live state
   always_comb begin
      rdata_nxt = rdata_r;
      if (i_reg_rd) begin
         unique case (i_reg_addr)
            tps_pkg::ADDR_CTRL:      rdata_nxt = ctrl_r;
            tps_pkg::ADDR_GROUP_LO:  rdata_nxt = group_r[7:0];
            tps_pkg::ADDR_GROUP_HI:  rdata_nxt = group_r[15:8];
            tps_pkg::ADDR_PROX_CFG:  rdata_nxt = cfg_r;
            tps_pkg::ADDR_PROX_VAR:  rdata_nxt = pvar_r;
            tps_pkg::ADDR_PROX_ENV:  rdata_nxt = penv_r;
            tps_pkg::ADDR_FILT_LO:   rdata_nxt = filt_r[7:0];
            tps_pkg::ADDR_FILT_HI:   rdata_nxt = filt_r[15:8];
            tps_pkg::ADDR_RESULT_LO: rdata_nxt = result[7:0];
            tps_pkg::ADDR_RESULT_HI: rdata_nxt = result[15:8];
            tps_pkg::ADDR_LIVE_LO:   rdata_nxt = live_r[7:0];
            tps_pkg::ADDR_LIVE_HI:   rdata_nxt = live_r[15:8];
            default:                 rdata_nxt = tps_pkg::RST_BYTE;
         endcase
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl_r  <= tps_pkg::RST_BYTE;
         group_r <= tps_pkg::RST_WORD;
         cfg_r   <= tps_pkg::RST_BYTE;
         pvar_r  <= tps_pkg::RST_BYTE;
         penv_r  <= tps_pkg::RST_BYTE;
         rdata_r <= tps_pkg::RST_BYTE;
      end else begin
         ctrl_r  <= ctrl_nxt;
         group_r <= group_nxt;
         cfg_r   <= cfg_nxt;
         pvar_r  <= pvar_nxt;
         penv_r  <= penv_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // ==========================================
   // Live touch detection with hysteresis
   logic [12:0] delta_r [tps_pkg::NCH];
   logic [12:0] delta_nxt [tps_pkg::NCH];
   logic [12:0] samp_delta;
   logic [12:0] thr_set;
   logic [12:0] thr_hold;

   always_comb begin
      samp_delta = (i_samp_cal > i_samp_imp) ? i_samp_cal - i_samp_imp : 13'h0000;
      thr_set    = {5'h00, i_touch_thr};
      thr_hold   = {6'h00, i_touch_thr[7:1]};
   end

   genvar gc;
   generate
      for (gc = 0; gc < tps_pkg::NCH; gc++) begin : g_chan
         always_comb begin
            live_nxt[gc]  = live_r[gc];
            delta_nxt[gc] = delta_r[gc];
            if (i_samp_vld && (i_samp_chan == 4'(gc))) begin
               delta_nxt[gc] = samp_delta;
               live_nxt[gc]  = live_r[gc] ? (samp_delta > thr_hold) : (samp_delta > thr_set);
            end
         end
         always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
            if (!i_rst_n) begin
               live_r[gc]  <= 1'b0;
               delta_r[gc] <= tps_pkg::RST_IMP;
            end else begin
               live_r[gc]  <= live_nxt[gc];
               delta_r[gc] <= delta_nxt[gc];
            end
         end
      end
   endgenerate

   // ==========================================
   // Key filter: keep the largest changes in the group
   logic [15:0] cand;
   logic [15:0] picked;
   logic [1:0]  mode;
   logic [12:0] best;
   logic [3:0]  best_i;
   logic        found;

   always_comb begin
      mode   = ctrl_r[tps_pkg::CTRL_MODE_MSB:0];
      cand   = live_r & group_r;
      picked = 16'h0000;
      best   = 13'h0000;
      best_i = 4'h0;
      found  = 1'b0;
      for (int p = 0; p < 3; p++) begin
         found  = 1'b0;
         best   = 13'h0000;
         best_i = 4'h0;
         for (int c = 0; c < tps_pkg::NCH; c++) begin
            if (cand[c] && !picked[c] && (!found || delta_r[c] > best)) begin
               found  = 1'b1;
               best   = delta_r[c];
               best_i = 4'(c);
            end
         end
         if (found && (p < int'(mode))) begin
            picked[best_i] = 1'b1;
         end
      end
      if (mode == 2'h0) begin
         filt_nxt = live_r;
      end else begin
         filt_nxt = (live_r & ~group_r) | picked;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         filt_r <= tps_pkg::RST_WORD;
      end else begin
         filt_r <= filt_nxt;
      end
   end

   // ==========================================
   // Proximity engine
   logic        prox_en;
   logic        prox_samp;
   logic        dith_vld;
   logic [12:0] dith;
   logic        force_cal;
   logic [12:0] cal_r,    cal_nxt;
   logic        done_r,   done_nxt;
   logic        det_r,    det_nxt;
   logic [4:0]  icnt_r,   icnt_nxt;
   logic [4:0]  intv;
   logic [12:0] diff;
   logic [2:0]  intv_code;

   always_comb begin
      prox_en   = ctrl_r[tps_pkg::CTRL_PROX_EN];
      prox_samp = i_samp_vld && (i_samp_chan == ctrl_r[tps_pkg::CTRL_PICK_MSB:tps_pkg::CTRL_PICK_LSB]);
      force_cal = penv_r[tps_pkg::ENV_FORCE];
   end

   tps_dither u_dither (
      .i_clk_sys  (i_clk_sys),
      .i_rst_n    (i_rst_n),
      .i_en       (prox_en),
      .i_samp_vld (prox_samp),
      .i_imp      (i_samp_imp),
      .i_dith_sel (cfg_r[tps_pkg::CFG_DITH_MSB:tps_pkg::CFG_DITH_LSB]),
      .o_dith_vld (dith_vld),
      .o_dith     (dith)
   );

   always_comb begin
      intv_code = cfg_r[tps_pkg::CFG_INTV_MSB:tps_pkg::CFG_INTV_LSB];
      if (intv_code > tps_pkg::INTV_MAX_CODE) begin
         intv_code = tps_pkg::INTV_MAX_CODE;
      end
      intv     = 5'h01 << intv_code;
      diff     = (dith > cal_r) ? dith - cal_r : cal_r - dith;
      cal_nxt  = cal_r;
      done_nxt = done_r;
      det_nxt  = det_r;
      icnt_nxt = icnt_r;
      if (force_cal && !done_r) begin
         done_nxt = 1'b0;
      end
      if (!prox_en) begin
         det_nxt  = 1'b0;
         icnt_nxt = 5'h00;
      end else if (dith_vld) begin
         det_nxt = (diff > {5'h00, pvar_r});
         if (force_cal) begin
            cal_nxt  = dith;
            done_nxt = 1'b1;
            icnt_nxt = 5'h00;
         end else if (icnt_r + 5'h01 >= intv) begin
            icnt_nxt = 5'h00;
            if (diff < {6'h00, penv_r[6:0]}) begin
               cal_nxt = dith;
            end
            done_nxt = 1'b1;
         end else begin
            icnt_nxt = icnt_r + 5'h01;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cal_r  <= tps_pkg::RST_IMP;
         done_r <= 1'b0;
         det_r  <= 1'b0;
         icnt_r <= 5'h00;
      end else begin
         cal_r  <= cal_nxt;
         // Host raising the force bit drops the done flag
         done_r <= (i_reg_wr && i_reg_addr == tps_pkg::ADDR_PROX_ENV && i_reg_wdata[tps_pkg::ENV_FORCE]
                    && !force_cal) ? 1'b0 : done_nxt;
         det_r  <= det_nxt;
         icnt_r <= icnt_nxt;
      end
   end

   always_comb begin
      result = {det_r, done_r, 1'b0,
                (cfg_r[tps_pkg::CFG_ACC_MSB:0] == tps_pkg::ACC_CAL) ? cal_r : dith};
   end

   assign o_reg_rdata     = rdata_r;
   assign o_filtered_keys = filt_r;
   assign o_prox_detected = det_r;

   // ==========================================
   // Checks
   a_live_set: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      i_samp_vld && (samp_delta > thr_set) |=> live_r[$past(i_samp_chan)]) else $error("Touch not set");
   a_live_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      i_samp_vld && (samp_delta <= thr_hold) |=> !live_r[$past(i_samp_chan)]) else $error("Touch not cleared");
   a_filt_bypass: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (mode == 2'h0) |=> (filt_r == $past(live_r))) else $error("Unfiltered word differs");
   a_filt_one: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      (mode == 2'h1) |=> ($countones(filt_r & $past(group_r)) <= 1)) else $error("Too many keys kept");
   a_force_load: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      prox_en && force_cal && dith_vld |=> (cal_r == $past(dith)) && done_r) else $error("Forced load missed");
   a_force_busy: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      i_reg_wr && (i_reg_addr == tps_pkg::ADDR_PROX_ENV) && i_reg_wdata[7] && !force_cal |=> !done_r)
      else $error("Done not cleared");
   a_prox_detect: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      prox_en && dith_vld |=> (det_r == ($past(diff) > {5'h00, $past(pvar_r)}))) else $error("Detect wrong");
   a_rd_live: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      i_reg_rd && (i_reg_addr == tps_pkg::ADDR_LIVE_LO) |=> (o_reg_rdata == $past(live_r[7:0])))
      else $error("Live read stale");
   a_rd_reserved: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      i_reg_rd && (i_reg_addr == tps_pkg::ADDR_RESULT_HI) |=> !o_reg_rdata[5]) else $error("Bit 13 set");
endmodule : tps_status
`default_nettype wire

// File: verif/touch_proximity_status_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
   $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module touch_proximity_status_tb;
   logic        i_clk_sys, i_rst_n, reg_wr, reg_rd, samp_vld, o_prox_detected, done_m, det, ok;
   logic [7:0]  reg_addr, reg_wdata, o_reg_rdata, rd_b, thr, vth, v, env_m;
   logic [3:0]  samp_chan;
   logic [2:0]  cd;
   logic [12:0] samp_imp, samp_cal, dith_m, cal_m, imp, df;
   logic [12:0] delta_m [16];
   logic [15:0] o_filtered_keys, live_m, e16;
   logic [17:0] sum;
   logic [7:0]  rst_a [7] = '{8'h96, 8'h97, 8'h98, 8'hb0, 8'hb1, 8'hb4, 8'ha0};
   int          num_errors, samples_checked, seed, n, i, d, p, k;

   tps_status u_dut (
      .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_reg_addr(reg_addr), .i_reg_wr(reg_wr),
      .i_reg_wdata(reg_wdata), .i_reg_rd(reg_rd), .i_samp_vld(samp_vld), .i_samp_chan(samp_chan),
      .i_samp_imp(samp_imp), .i_samp_cal(samp_cal), .i_touch_thr(thr), .o_reg_rdata(o_reg_rdata),
      .o_filtered_keys(o_filtered_keys), .o_prox_detected(o_prox_detected));
   tps_host_model u_host (
      .i_clk_sys(i_clk_sys), .i_reg_rdata(o_reg_rdata), .o_reg_addr(reg_addr),
      .o_reg_wr(reg_wr), .o_reg_wdata(reg_wdata), .o_reg_rd(reg_rd));

   initial begin
      i_clk_sys = 1'b0;
      forever #50 i_clk_sys = ~i_clk_sys;
   end
   initial begin
      repeat (100000) @(posedge i_clk_sys);
      num_errors++;
      finish_test();
   end
   // ==========================================
   // Sample source and expected live state
   task automatic samp(input logic [3:0] c, input logic [12:0] im, input logic [12:0] ca);
      logic [12:0] dl;
      dl = (im >= ca) ? 13'h0000 : ca - im;
      if (dl > thr) live_m[c] = 1'b1;
      else if (dl <= (thr >> 1)) live_m[c] = 1'b0;
      delta_m[c] = dl;
      @(posedge i_clk_sys);
      samp_vld <= 1'b1;
      samp_chan <= c;
      samp_imp <= im;
      samp_cal <= ca;
      @(posedge i_clk_sys);
      samp_vld <= 1'b0;
      samp_imp <= ~im;
      samp_cal <= ~ca;
   endtask : samp
   function automatic logic [15:0] topk(input int kk);
      logic [15:0] r;
      int b;
      r = 16'h0000;
      for (int j = 0; j < kk; j++) begin
         b = -1;
         for (int c = 0; c < 16; c++)
            if (live_m[c] && !r[c] && (b < 0 || delta_m[c] > delta_m[b])) b = c;
         if (b >= 0) r[b] = 1'b1;
      end
      return r;
   endfunction : topk
   task automatic finish_test();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : finish_test
   // ==========================================
   // Main sequence
   initial begin
      i_rst_n = 1'b0;
      samp_vld = 1'b0;
      samp_chan = 4'h0;
      samp_imp = 13'h0000;
      samp_cal = 13'h0000;
      seed = 32'he96e;
      thr = 8'h10 + 8'($random(seed) & 8'h3f);
      num_errors = 0;
      samples_checked = 0;
      live_m = 16'h0000;
      cal_m = 13'h0000;
      done_m = 1'b0;
      for (i = 0; i < 16; i++) delta_m[i] = 13'h0000;
      repeat (4) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      foreach (rst_a[j]) begin
         u_host.rd(rst_a[j], rd_b);
         `CHK(rd_b, 8'h00)
      end
      for (i = 0; i < 5; i++) begin
         v = 8'($random(seed)) & 8'h7f;
         u_host.wr(rst_a[i], v);
         u_host.rd(rst_a[i], rd_b);
         `CHK(rd_b, (i < 3) ? v : 8'h00)
      end
      for (n = 0; n < 80; n++) begin
         k = $unsigned($random(seed)) % 6;
         imp = 13'h1000 | 13'($random(seed) & 12'hfff);
         case (k)
            0: sum = 18'(thr) + 18'h1;
            1: sum = 18'(thr);
            2: sum = 18'(thr >> 1) + 18'h1;
            3: sum = 18'(thr >> 1);
            default: sum = 18'($random(seed) & 8'hff);
         endcase
         samp(4'($random(seed)), imp - 13'(sum), (k == 5) ? imp - 13'h1 : imp);
         repeat (3) @(posedge i_clk_sys);
         #1;
         `CHK(o_filtered_keys, live_m)
         u_host.rd(8'h9a, rd_b);
         `CHK(rd_b, live_m[7:0])
         u_host.rd(8'hb4, rd_b);
         `CHK(rd_b, live_m[7:0])
         u_host.rd(8'hb5, rd_b);
         `CHK(rd_b, live_m[15:8])
      end
      u_host.wr(8'h92, 8'hff);
      u_host.wr(8'h93, 8'hff);
      for (i = 0; i < 16; i++) samp(4'(i), 13'h1000, 13'h1000);
      samp(4'h3, 13'h1000 - 13'(thr) - 13'h5, 13'h1000);
      samp(4'h9, 13'h1000 - 13'(thr) - 13'h28, 13'h1000);
      samp(4'hc, 13'h1000 - 13'(thr) - 13'h14, 13'h1000);
      for (i = 0; i < 4; i++) begin
         u_host.wr(8'h90, 8'(i));
         repeat (3) @(posedge i_clk_sys);
         #1;
         `CHK(o_filtered_keys, (i == 0) ? live_m : topk(i))
      end
      // Low byte left out of the group passes unfiltered
      u_host.wr(8'h90, 8'h01);
      u_host.wr(8'h92, 8'h00);
      repeat (3) @(posedge i_clk_sys);
      #1;
      `CHK(o_filtered_keys, (live_m & 16'h00ff) | topk(1))
      // ==========================================
      // Proximity rounds, one per dithering code
      vth = 8'h08 + 8'($random(seed) & 8'h1f);
      env_m = 8'h40 | (8'($random(seed)) & 8'h3f);
      u_host.wr(8'h97, vth);
      u_host.wr(8'h98, env_m);
      for (d = 0; d < 4; d++) begin
         p = $random(seed);
         cd = (d == 1) ? 3'h0 : 3'($random(seed));
         u_host.wr(8'h90, 8'h00);
         u_host.wr(8'h96, {d[1:0], 1'b0, cd, 1'b0, d[0]});
         u_host.wr(8'h90, {p[3:0], 4'b0100});
         if (d == 2) u_host.wr(8'h98, 8'h80);
         sum = 18'h0;
         for (n = 0; n < (4 << d); n++) begin
            imp = (d == 3) ? 13'h1fff - 13'($random(seed) & 6'h3f) :
                  (d == 1) ? 13'($random(seed) & 4'hf) : 13'($random(seed) & 10'h3ff);
            sum = sum + 18'(imp);
            samp(p[3:0], imp, imp);
            samp(p[3:0] ^ 4'h1, imp ^ 13'h0155, imp);
         end
         dith_m = ((sum >> d) > 18'h1fff) ? 13'h1fff : 13'(sum >> d);
         // Detect uses the old calibration; calibration updates in the same cycle
         df = (dith_m > cal_m) ? dith_m - cal_m : cal_m - dith_m;
         det = df > 13'(vth);
         if (d == 2 || (cd == 3'h0 && df < 13'(env_m[6:0]))) cal_m = dith_m;
         if (d == 2 || cd == 3'h0) done_m = 1'b1;
         e16 = {det, done_m, 1'b0, d[0] ? cal_m : dith_m};
         repeat (3) @(posedge i_clk_sys);
         u_host.rd(8'hb0, rd_b);
         `CHK(rd_b, e16[7:0])
         if (d == 1) `CHK(rd_b, dith_m[7:0])
         u_host.rd(8'hb1, rd_b);
         `CHK(rd_b, e16[15:8])
         if (d == 1) `CHK(rd_b[6], 1'b1)
         `CHK(o_prox_detected, det)
         if (d == 2) begin
            u_host.poll_done(ok);
            `CHK(ok, 1'b1)
            env_m = 8'h00;
         end
      end
      u_host.wr(8'h90, 8'h00);
      repeat (3) @(posedge i_clk_sys);
      #1;
      `CHK(o_prox_detected, 1'b0)
      finish_test();
   end
endmodule : touch_proximity_status_tb
`default_nettype wire

// File: verif/tps_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Host side of the register bus
module tps_host_model (
   input  wire logic       i_clk_sys,
   input  wire logic [7:0] i_reg_rdata,
   output logic [7:0]      o_reg_addr,
   output logic            o_reg_wr,
   output logic [7:0]      o_reg_wdata,
   output logic            o_reg_rd
);
   initial begin
      o_reg_addr = 8'h00;
      o_reg_wr = 1'b0;
      o_reg_wdata = 8'h00;
      o_reg_rd = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      o_reg_addr <= a;
      o_reg_wdata <= d;
      o_reg_wr <= 1'b1;
      @(posedge i_clk_sys);
      o_reg_wr <= 1'b0;
      o_reg_addr <= ~a;
      o_reg_wdata <= ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk_sys);
      o_reg_addr <= a;
      o_reg_rd <= 1'b1;
      @(posedge i_clk_sys);
      o_reg_rd <= 1'b0;
      o_reg_addr <= ~a;
      @(posedge i_clk_sys);
      d = i_reg_rdata;
   endtask : rd
   // Poll done flag, then drop the force bit
   task automatic poll_done(output logic ok);
      logic [7:0] b;
      ok = 1'b0;
      for (int k = 0; k < 20 && !ok; k++) begin
         rd(8'hb1, b);
         ok = (b[6] === 1'b1);
      end
      if (ok) wr(8'h98, 8'h00);
   endtask : poll_done
endmodule : tps_host_model
`default_nettype wire
